// File: include/letr_pkg.sv
package letr_pkg;
  // Cell geometry
  localparam int LETR_AW = 4;
  localparam int LETR_WORDS = 16;
  localparam int LETR_LANES = 2;
  localparam int LETR_LANE_F = 0;
  localparam int LETR_LANE_G = 1;
  localparam int LETR_PIN_W = 2 * LETR_AW + 4;
  // Wishbone widths
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int WB_SW = 4;
  // Register offsets
  localparam logic [7:0] LETR_OFS_CFG = 8'h00;
  localparam logic [7:0] LETR_OFS_HTAB = 8'h04;
  localparam logic [7:0] LETR_OFS_GSR = 8'h08;
  localparam logic [7:0] LETR_OFS_STAT = 8'h0c;
  localparam logic [7:0] LETR_OFS_MEMF = 8'h10;
  localparam logic [7:0] LETR_OFS_MEMG = 8'h14;
  // Field positions and widths
  localparam int LETR_MODE_W = 2;
  localparam int LETR_SRC_W = 2;
  localparam int LETR_HTAB_W = 8;
  localparam int LETR_CNT_W = 8;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_FALL_BIT = 2;
  localparam int CFG_OPP_BIT = 3;
  localparam int CFG_SRCX_LSB = 4;
  localparam int CFG_SRCY_LSB = 6;
  localparam int GSR_CMD_BIT = 0;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_ADDR_LSB = 8;
  localparam int STAT_DATA_BIT = 13;
  // Reset values
  localparam logic [LETR_HTAB_W-1:0] LETR_HTAB_RST = 8'h00;
  localparam logic [LETR_CNT_W-1:0] LETR_CNT_RST = 8'h00;
  typedef enum logic [1:0] {
    LETR_M16X2 = 2'h0,
    LETR_M16X1 = 2'h1,
    LETR_M32X1 = 2'h2
  } letr_mode_type;
  typedef enum logic [1:0] {
    LETR_SRC_F = 2'h0,
    LETR_SRC_G = 2'h1,
    LETR_SRC_H = 2'h2,
    LETR_SRC_AUX0 = 2'h3
  } letr_src_type;
  typedef enum logic {
    LETR_WS_IDLE = 1'b0,
    LETR_WS_PULSE = 1'b1
  } letr_wstate_type;
endpackage

// File: include/letr_lut_if.sv
interface letr_lut_if;
  import letr_pkg::*;
  logic [LETR_AW-1:0] waddr;
  logic [LETR_AW-1:0] raddr;
  logic din;
  logic wpulse;
  logic dout;
  logic [LETR_WORDS-1:0] contents;
  modport ctrl (output waddr, output raddr, output din, output wpulse,
                input dout, input contents);
  modport mem (input waddr, input raddr, input din, input wpulse,
               output dout, output contents);
endinterface

// File: rtl/letr_lut16.sv
module letr_lut16 #(
  parameter logic [letr_pkg::LETR_WORDS-1:0] INIT = 16'h0000
) (
  // Clock and configuration reset
  input wire logic clk,
  input wire logic rst,
  // Table access
  letr_lut_if.mem bus
);
  import letr_pkg::*;

  logic [LETR_WORDS-1:0] cells;

  // Preload only at configuration; no cell-flop preset path reaches here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cells <= INIT;
    end else if (bus.wpulse) begin
      cells[bus.waddr] <= bus.din;
    end
  end

  // Asynchronous read of the addressed word
  assign bus.dout = cells[bus.raddr];
  assign bus.contents = cells;

  property lut_store_p;
    @(posedge clk) disable iff (rst)
    bus.wpulse |=> cells[$past(bus.waddr)] == $past(bus.din);
  endproperty
  AST_LUT_STORE: assert property (lut_store_p)
    else $error("table word not stored by write pulse");

  AST_LUT_HOLD: assert property (@(posedge clk) disable iff (rst)
    !bus.wpulse |=> $stable(cells))
    else $error("table changed without write pulse");
endmodule

// File: rtl/letr_top.sv
// The placing of the registers and the Wishbone register port were decided locally.
module letr_top #(
  parameter logic [letr_pkg::LETR_WORDS-1:0] INIT_F = 16'h0000,
  parameter logic [letr_pkg::LETR_WORDS-1:0] INIT_G = 16'h0000,
  parameter logic FF_INIT_X = 1'b0,
  parameter logic FF_INIT_Y = 1'b0
) (
  // Clock and configuration reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic [letr_pkg::WB_AW-1:0] WB_ADR_I,
  input wire logic [letr_pkg::WB_DW-1:0] WB_DAT_I,
  input wire logic [letr_pkg::WB_SW-1:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [letr_pkg::WB_DW-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Cell write side
  input wire logic WCLK,
  input wire logic WRITE_STROBE,
  input wire logic [letr_pkg::LETR_AW-1:0] F_ADDR,
  input wire logic [letr_pkg::LETR_AW-1:0] G_ADDR,
  input wire logic AUX_INPUT_ZERO,
  input wire logic AUX_INPUT_ONE,
  // Cell outputs
  output logic PORT_READ_OUT_F,
  output logic PORT_READ_OUT_G,
  output logic COMB_OUT_H,
  output logic CELL_Q_X,
  output logic CELL_Q_Y
);
  import letr_pkg::*;

  logic [LETR_PIN_W-1:0] pin_meta;
  logic [LETR_PIN_W-1:0] pin_sync;
  logic wclk_s;
  logic we_s;
  logic aux1_s;
  logic aux0_s;
  logic [LETR_AW-1:0] ga_s;
  logic [LETR_AW-1:0] fa_s;
  logic wclk_d;
  logic rise;
  logic fall;
  logic act_edge;
  logic ff_edge;
  letr_mode_type cfg_mode;
  logic cfg_fall;
  logic cfg_opp;
  letr_src_type cfg_srcx;
  letr_src_type cfg_srcy;
  logic [LETR_HTAB_W-1:0] htab;
  logic gsr_pulse;
  letr_wstate_type wstate;
  letr_wstate_type next_wstate;
  logic [LETR_AW-1:0] cap_fa;
  logic [LETR_AW-1:0] cap_ga;
  logic cap_a0;
  logic cap_a1;
  logic cap_we;
  logic wr_pulse;
  logic mode32;
  logic mode16x2;
  logic [LETR_LANES-1:0] lane_we;
  logic [LETR_LANES-1:0] lane_din;
  logic [LETR_LANES-1:0] lane_dout;
  logic [LETR_AW-1:0] lane_waddr [LETR_LANES];
  logic [LETR_AW-1:0] lane_raddr [LETR_LANES];
  logic [LETR_WORDS-1:0] lane_contents [LETR_LANES];
  logic f_out;
  logic g_out;
  logic h_out;
  logic [LETR_CNT_W-1:0] wr_count;
  logic [LETR_AW:0] last_addr;
  logic last_data;
  logic bus_req;
  logic bus_wr;
  logic [WB_DW-1:0] rdata;

  // Pin inputs: two-stage synchroniser, then an edge stage on the clock
  assign {wclk_s, we_s, aux1_s, aux0_s, ga_s, fa_s} = pin_sync;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pin_meta <= '0;
      pin_sync <= '0;
      wclk_d <= 1'b0;
    end else begin
      pin_meta <= {WCLK, WRITE_STROBE, AUX_INPUT_ONE, AUX_INPUT_ZERO, G_ADDR, F_ADDR};
      pin_sync <= pin_meta;
      wclk_d <= wclk_s;
    end
  end

  assign rise = wclk_s & ~wclk_d;
  assign fall = ~wclk_s & wclk_d;
  // Write edge sense from cfg_fall; cell flops take the opposite edge when cfg_opp is set
  assign act_edge = cfg_fall ? fall : rise;
  assign ff_edge = (cfg_opp ^ cfg_fall) ? fall : rise;

  // Capture at the active edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cap_fa <= '0;
      cap_ga <= '0;
      cap_a0 <= 1'b0;
      cap_a1 <= 1'b0;
      cap_we <= 1'b0;
    end else if (act_edge) begin
      cap_fa <= fa_s;
      cap_ga <= ga_s;
      cap_a0 <= aux0_s;
      cap_a1 <= aux1_s;
      cap_we <= we_s;
    end
  end

  // Internal write pulse sequencer
  always_comb begin
    case (wstate)
      LETR_WS_IDLE: begin
        next_wstate = (act_edge && we_s) ? LETR_WS_PULSE : LETR_WS_IDLE;
      end
      LETR_WS_PULSE: begin
        next_wstate = LETR_WS_IDLE;
      end
      default: begin
        next_wstate = LETR_WS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wstate <= LETR_WS_IDLE;
    end else begin
      wstate <= next_wstate;
    end
  end

  assign wr_pulse = (wstate == LETR_WS_PULSE);
  assign mode32 = (cfg_mode == LETR_M32X1);
  assign mode16x2 = (cfg_mode == LETR_M16X2);

  // Lane steering per organisation
  always_comb begin
    lane_we[LETR_LANE_F] = wr_pulse && (!mode32 || !cap_a1);
    lane_we[LETR_LANE_G] = wr_pulse && (mode16x2 || (mode32 && cap_a1));
    lane_din[LETR_LANE_F] = cap_a0;
    lane_din[LETR_LANE_G] = mode16x2 ? cap_a1 : cap_a0;
    lane_waddr[LETR_LANE_F] = cap_fa;
    lane_waddr[LETR_LANE_G] = mode32 ? cap_fa : cap_ga;
    lane_raddr[LETR_LANE_F] = fa_s;
    lane_raddr[LETR_LANE_G] = mode32 ? fa_s : ga_s;
  end

  letr_lut_if lut_bus [LETR_LANES] ();

  for (genvar i = 0; i < LETR_LANES; i++) begin : g_lane
    assign lut_bus[i].waddr = lane_waddr[i];
    assign lut_bus[i].raddr = lane_raddr[i];
    assign lut_bus[i].din = lane_din[i];
    assign lut_bus[i].wpulse = lane_we[i];
    assign lane_dout[i] = lut_bus[i].dout;
    assign lane_contents[i] = lut_bus[i].contents;
    letr_lut16 #(
      .INIT((i == LETR_LANE_F) ? INIT_F : INIT_G)
    ) u_lut (
      .clk(CORE_CLK),
      .rst(RST),
      .bus(lut_bus[i])
    );
  end

  // Outputs follow the table without waiting for the write clock
  assign f_out = (mode32 && aux1_s) ? lane_dout[LETR_LANE_G] : lane_dout[LETR_LANE_F];
  assign g_out = lane_dout[LETR_LANE_G];
  assign h_out = htab[{aux1_s, lane_dout[LETR_LANE_G], lane_dout[LETR_LANE_F]}];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PORT_READ_OUT_F <= 1'b0;
      PORT_READ_OUT_G <= 1'b0;
      COMB_OUT_H <= 1'b0;
    end else begin
      PORT_READ_OUT_F <= f_out;
      PORT_READ_OUT_G <= g_out;
      COMB_OUT_H <= h_out;
    end
  end

  function automatic logic pick(letr_src_type s, logic f, logic g, logic h, logic a);
    case (s)
      LETR_SRC_F: pick = f;
      LETR_SRC_G: pick = g;
      LETR_SRC_H: pick = h;
      default: pick = a;
    endcase
  endfunction

  // Cell flops; preset/clear acts here only, never on the tables
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CELL_Q_X <= FF_INIT_X;
      CELL_Q_Y <= FF_INIT_Y;
    end else if (gsr_pulse) begin
      CELL_Q_X <= FF_INIT_X;
      CELL_Q_Y <= FF_INIT_Y;
    end else if (ff_edge) begin
      CELL_Q_X <= pick(cfg_srcx, f_out, g_out, h_out, aux0_s);
      CELL_Q_Y <= pick(cfg_srcy, f_out, g_out, h_out, aux0_s);
    end
  end

  // Write activity status
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wr_count <= LETR_CNT_RST;
      last_addr <= '0;
      last_data <= 1'b0;
    end else if (wr_pulse) begin
      wr_count <= wr_count + 1'b1;
      last_addr <= {mode32 && cap_a1, cap_fa};
      last_data <= lane_din[LETR_LANE_F] | (lane_we[LETR_LANE_G] & lane_din[LETR_LANE_G]);
    end
  end

  // Wishbone slave: ack one cycle after request, write at the acked edge
  assign bus_req = WB_CYC_I & WB_STB_I;
  assign bus_wr = bus_req & WB_ACK_O & WB_WE_I & WB_SEL_I[0];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req & ~WB_ACK_O;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg_mode <= LETR_M16X2;
      cfg_fall <= 1'b0;
      cfg_opp <= 1'b0;
      cfg_srcx <= LETR_SRC_F;
      cfg_srcy <= LETR_SRC_G;
      htab <= LETR_HTAB_RST;
    end else if (bus_wr && WB_ADR_I == LETR_OFS_CFG) begin
      cfg_mode <= letr_mode_type'(WB_DAT_I[CFG_MODE_LSB +: LETR_MODE_W]);
      cfg_fall <= WB_DAT_I[CFG_FALL_BIT];
      cfg_opp <= WB_DAT_I[CFG_OPP_BIT];
      cfg_srcx <= letr_src_type'(WB_DAT_I[CFG_SRCX_LSB +: LETR_SRC_W]);
      cfg_srcy <= letr_src_type'(WB_DAT_I[CFG_SRCY_LSB +: LETR_SRC_W]);
    end else if (bus_wr && WB_ADR_I == LETR_OFS_HTAB) begin
      htab <= WB_DAT_I[LETR_HTAB_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      gsr_pulse <= 1'b0;
    end else begin
      gsr_pulse <= bus_wr && WB_ADR_I == LETR_OFS_GSR && WB_DAT_I[GSR_CMD_BIT];
    end
  end

  always_comb begin
    rdata = '0;
    case (WB_ADR_I)
      LETR_OFS_CFG: begin
        rdata[CFG_MODE_LSB +: LETR_MODE_W] = cfg_mode;
        rdata[CFG_FALL_BIT] = cfg_fall;
        rdata[CFG_OPP_BIT] = cfg_opp;
        rdata[CFG_SRCX_LSB +: LETR_SRC_W] = cfg_srcx;
        rdata[CFG_SRCY_LSB +: LETR_SRC_W] = cfg_srcy;
      end
      LETR_OFS_HTAB: rdata[LETR_HTAB_W-1:0] = htab;
      LETR_OFS_STAT: begin
        rdata[STAT_CNT_LSB +: LETR_CNT_W] = wr_count;
        rdata[STAT_ADDR_LSB +: LETR_AW + 1] = last_addr;
        rdata[STAT_DATA_BIT] = last_data;
      end
      LETR_OFS_MEMF: rdata[LETR_WORDS-1:0] = lane_contents[LETR_LANE_F];
      LETR_OFS_MEMG: rdata[LETR_WORDS-1:0] = lane_contents[LETR_LANE_G];
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WB_DAT_O <= '0;
    end else if (bus_req && !WB_ACK_O) begin
      WB_DAT_O <= rdata;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_WR_NEEDS_STROBE: assert property (wr_pulse |-> $past(act_edge && we_s))
    else $error("write pulse without strobe at active edge");
  AST_CAPTURE: assert property (act_edge |=> cap_fa == $past(fa_s) && cap_we == $past(we_s))
    else $error("address or strobe not captured at active edge");
  AST_POLARITY: assert property (act_edge |-> (cfg_fall ? !wclk_s : wclk_s))
    else $error("active edge has wrong sense");
  AST_FF_EDGE: assert property ((ff_edge && act_edge) |-> !cfg_opp)
    else $error("cell flops clocked on ram edge in opposite mode");
  AST_SHARED_SENSE: assert property ((mode16x2 && wr_pulse) |-> &lane_we)
    else $error("tables written on different edges");
  AST_STROBE_LOW: assert property ((act_edge && !we_s && wstate == LETR_WS_IDLE) |=> !wr_pulse)
    else $error("write with low strobe");
  AST_SINGLE_TABLE: assert property ((cfg_mode == LETR_M16X1) |-> !lane_we[LETR_LANE_G])
    else $error("second table written in single 16x1 mode");
  AST_A4_SELECT: assert property ((mode32 && wr_pulse) |->
    lane_we[LETR_LANE_G] == cap_a1 && lane_we[LETR_LANE_F] == !cap_a1)
    else $error("fifth address bit steers wrong table");
  AST_H_FUNC: assert property (##1 COMB_OUT_H ==
    $past(htab[{aux1_s, lane_dout[LETR_LANE_G], lane_dout[LETR_LANE_F]}]))
    else $error("third table output mismatch");
  AST_GSR_KEEPS_MEM: assert property ((gsr_pulse && !wr_pulse) |=>
    $stable(lane_contents[LETR_LANE_F]) && $stable(lane_contents[LETR_LANE_G]))
    else $error("preset changed memory contents");
  AST_READ_FOLLOWS: assert property (##1 PORT_READ_OUT_F == $past(f_out))
    else $error("read output not following table");
  AST_NEW_WORD: assert property ((lane_we[LETR_LANE_F] && !mode32 &&
    lane_raddr[LETR_LANE_F] == lane_waddr[LETR_LANE_F]) ##1 $stable(fa_s)
    |=> PORT_READ_OUT_F == $past(lane_din[LETR_LANE_F], 2))
    else $error("new word not shown after write");

  COV_WRITE_16X2: cover property (mode16x2 && wr_pulse);
  COV_WRITE_32X1_HIGH: cover property (mode32 && wr_pulse && cap_a1);
  COV_FALLING_WRITE: cover property (cfg_fall && act_edge && we_s);
  COV_GSR: cover property (gsr_pulse);
endmodule

// File: test/letr_partner.sv
module letr_partner (
  // Clock
  input wire logic clk,
  // Cell write side
  output logic wclk,
  output logic strobe,
  output logic [letr_pkg::LETR_AW-1:0] f_addr,
  output logic [letr_pkg::LETR_AW-1:0] g_addr,
  output logic aux0,
  output logic aux1
);
  timeunit 1ns;
  timeprecision 1ps;
  import letr_pkg::*;
  logic idle;
  initial begin
    wclk = 1'b0;
    idle = 1'b0;
    strobe = 1'b0;
    f_addr = '0;
    g_addr = '0;
    aux0 = 1'b0;
    aux1 = 1'b0;
  end
  // Park the write clock at its inactive level
  task automatic rest(input logic lvl);
    @(posedge clk);
    strobe <= 1'b0;
    wclk <= lvl;
    idle = lvl;
    repeat (4) @(posedge clk);
  endtask
  task automatic point(input logic [LETR_AW-1:0] fa, input logic [LETR_AW-1:0] ga,
                       input logic d1);
    @(posedge clk);
    f_addr <= fa;
    g_addr <= ga;
    aux1 <= d1;
  endtask
  task automatic cycle(input logic [LETR_AW-1:0] fa, input logic [LETR_AW-1:0] ga,
                       input logic d0, input logic d1, input logic we);
    point(fa, ga, d1);
    aux0 <= d0;
    strobe <= we;
    repeat (4) @(posedge clk);
    wclk <= ~idle;
    repeat (4) @(posedge clk);
    wclk <= idle;
    repeat (4) @(posedge clk);
    strobe <= 1'b0;
  endtask
endmodule

// File: test/letr_top_tb_top.sv
module letr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import letr_pkg::*;
  localparam logic [LETR_WORDS-1:0] INIT_F = 16'h5a3c;
  logic core_clk, rst, wclk, strobe, aux0, aux1, we, cyc, stb, ack, pf, pg, ph, qx, qy;
  logic [WB_AW-1:0] adr;
  logic [WB_DW-1:0] wdat, rdat, q, r;
  logic [WB_SW-1:0] sel;
  logic [LETR_AW-1:0] fa, ga;
  logic [15:0] mf, mg;
  logic [7:0] htab, cfg;
  int err_count, samples_checked, mode, nwr;
  int order[4] = '{0, 2, 1, 3};
  logic [4:0] la;
  logic xo;

  letr_top #(.INIT_F(INIT_F)) i_dut (.CORE_CLK(core_clk), .RST(rst), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .WCLK(wclk), .WRITE_STROBE(strobe), .F_ADDR(fa),
    .G_ADDR(ga), .AUX_INPUT_ZERO(aux0), .AUX_INPUT_ONE(aux1), .PORT_READ_OUT_F(pf),
    .PORT_READ_OUT_G(pg), .COMB_OUT_H(ph), .CELL_Q_X(qx), .CELL_Q_Y(qy));
  letr_partner i_partner (.clk(core_clk), .wclk(wclk), .strobe(strobe), .f_addr(fa),
    .g_addr(ga), .aux0(aux0), .aux1(aux1));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED bus t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED pin t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      report_and_stop;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    chk_bus(q, exp);
  endtask
  task automatic check_regs;
    wb(1'b0, LETR_OFS_STAT, 32'h0, 4'hf);
    chk_bus({24'h0, q[7:0]}, {24'h0, nwr[7:0]});
    chk_bus({27'h0, q[12:8]}, {27'h0, la});
    rd(LETR_OFS_MEMF, {16'h0, mf});
    rd(LETR_OFS_MEMG, {16'h0, mg});
    rd(LETR_OFS_HTAB, {24'h0, htab});
  endtask
  task automatic check_cell;
    logic ef, eg;
    @(negedge core_clk);
    ef = (mode == 2 && aux1) ? mg[fa] : mf[fa];
    eg = (mode == 2) ? mg[fa] : mg[ga];
    chk_pin(pf, ef);
    chk_pin(pg, eg);
    chk_pin(ph, htab[{aux1, eg, mf[fa]}]);
  endtask
  // Partner write plus reference update
  task automatic wr(input logic [3:0] f, input logic [3:0] g, input logic d0,
                    input logic d1, input logic w);
    i_partner.cycle(f, g, d0, d1, w);
    if (w) begin
      nwr++;
      la = {mode == 2 && d1, f};
      if (mode == 0) begin
        mf[f] = d0;
        mg[g] = d1;
      end else if (mode == 2) begin
        if (d1) mg[f] = d0;
        else mf[f] = d0;
      end else begin
        mf[f] = d0;
      end
    end
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    mf = INIT_F;
    mg = 16'h0;
    htab = 8'h00;
    nwr = 0;
    mode = 0;
    la = 5'h00;
  endtask

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    wdat = '0;
    sel = '0;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(32'h31a2478f));
    for (int f = 0; f < 2; f++) begin
      do_reset;
      i_partner.rest(1'b0);
      rd(LETR_OFS_CFG, 32'h40);
      rd(LETR_OFS_GSR, 32'h0);
      check_regs;
      htab = 8'($urandom);
      wb(1'b1, LETR_OFS_HTAB, {24'h0, htab}, 4'hf);
      wb(1'b1, LETR_OFS_HTAB, {24'h0, ~htab}, 4'he);
      wb(1'b1, 8'h1c, 32'hffffffff, 4'hf);
      rd(8'h1c, 32'h0);
      for (int m = 0; m < 4; m++) begin
        mode = order[m];
        r = $urandom;
        cfg = 8'(8'hc0 | mode | (f << 2) | (r[0] << 3));
        wb(1'b1, LETR_OFS_CFG, {24'h0, cfg}, 4'hf);
        rd(LETR_OFS_CFG, {24'h0, cfg});
        i_partner.rest(f[0]);
        for (int k = 0; k < 6; k++) begin
          r = $urandom;
          xo = (mode == 2 && r[9]) ? mg[r[3:0]] : mf[r[3:0]];
          wr(r[3:0], r[7:4], r[8], r[9], r[11:10] != 2'h0);
          check_cell;
          if (cfg[3]) xo = (mode == 2 && r[9]) ? mg[r[3:0]] : mf[r[3:0]];
          chk_pin(qx, xo);
          chk_pin(qy, r[8]);
          i_partner.point(r[15:12], r[19:16], r[20]);
          repeat (4) @(posedge core_clk);
          check_cell;
        end
        check_regs;
      end
      wr(fa, ga, 1'b1, aux1, 1'b0);
      wb(1'b1, LETR_OFS_GSR, 32'h1, 4'hf);
      repeat (3) @(posedge core_clk);
      chk_pin(qy, 1'b0);
      chk_pin(qx, 1'b0);
      check_regs;
    end
    report_and_stop;
  end
endmodule
